// >>> pkg/dwi_cfg.svh
`ifndef DWI_CFG_SVH
`define DWI_CFG_SVH
// Summary of operation
// RULE_01: two independent 6-bit volatile wiper position registers, one per pot
// RULE_02: each wiper value drives a one-hot select of 64 tap switches
// RULE_03: after reset each wiper loads preset zero before any command runs
// RULE_04: wiper is volatile; after reset its value comes only from preset zero
// RULE_05: four 6-bit preset registers per pot, host readable, writable, transferable
// RULE_06: any preset change is a programming cycle of at most 5 ms
// RULE_07: opcode 1001, index 00, returns selected wiper as third byte
// RULE_08: opcode 1010, index 00, loads data byte into selected wiper
// RULE_09: opcode 1011 returns the preset chosen by pot and index bits
// RULE_10: opcode 1100 programs data byte into the chosen preset
// RULE_11: opcode 1101 copies the chosen preset into that pot's wiper
// RULE_12: opcode 1110 copies selected wiper into its preset at index, nonvolatile
// RULE_13: opcode 0001, pot bit 0, copies indexed preset into both wipers
// RULE_14: opcode 1000, pot bit 0, stores both wipers into indexed presets
// RULE_15: opcode 0010, index 00, enables stepping of the selected wiper
// RULE_16: the step instruction changes a wiper one step at a time
// RULE_17: the tap follows a wiper change only after the response delay
// RULE_18: wiper-to-preset transfer is a nonvolatile write bounded by write time
// RULE_19: read and write instructions use address, instruction and one data byte
// RULE_20: other instructions use address plus instruction byte, no data byte
// RULE_21: after a programming stop, all requests are ignored until it ends
// RULE_22: guard low: data byte of preset write is not acknowledged, no programming
// RULE_23: each step with data high moves toward high end, low toward low end
// RULE_24: execute only when address bits equal the four strap inputs
// RULE_25: stepping saturates at 63 and 0, never wraps
// RULE_26: a returned 6-bit value sits in the low bits, upper two zero
// RULE_27: undefined opcodes or nonzero must-be-zero bits change nothing

// instruction byte fields
`define DWI_OP_HI        7
`define DWI_OP_LO        4
`define DWI_IDX_HI       3
`define DWI_IDX_LO       2
`define DWI_ZERO_BIT     1
`define DWI_POT_BIT      0
// opcodes
`define DWI_OP_RD_WIPER  4'h9
`define DWI_OP_WR_WIPER  4'ha
`define DWI_OP_RD_PRESET 4'hb
`define DWI_OP_WR_PRESET 4'hc
`define DWI_OP_PRE2WIP   4'hd
`define DWI_OP_WIP2PRE   4'he
`define DWI_OP_GANG_P2W  4'h1
`define DWI_OP_GANG_W2P  4'h8
`define DWI_OP_STEP      4'h2
// reset and blank values
`define DWI_WIPER_RST    6'h00
`define DWI_PRESET_BLANK 6'h20
`define DWI_TAP_RST      64'h0000_0000_0000_0001
`define DWI_WIPER_MAX    6'h3f
`define DWI_WIPER_MIN    6'h00
// timing
`define DWI_CORE_CLK_NS      10
`define DWI_NV_WRITE_TIME_NS 5000000
`define DWI_WIPER_RESP_NS    100
`define DWI_WIPER_RESP_CYC   ((`DWI_WIPER_RESP_NS + `DWI_CORE_CLK_NS - 1) / `DWI_CORE_CLK_NS)
`endif

// >>> pkg/dwi_pkg.sv
package dwi_pkg;
    // one latched instruction handed from the link to the core
    typedef struct packed {
        logic [3:0] op;
        logic [1:0] idx;
        logic       pot;
        logic [7:0] data;
    } dwi_cmd_s;

    typedef enum logic [1:0] {
        CORE_INIT,
        CORE_IDLE,
        CORE_NVWAIT
    } dwi_core_st_e;
endpackage

// >>> verilog/dwi_logic.sv
`timescale 1ns/1ps
`include "dwi_cfg.svh"
module dwi_logic #(
    parameter logic [3:0] DEV_TYPE    = 4'hc,                                          // arbitrary type code
    parameter int         NV_WRITE_CYC = `DWI_NV_WRITE_TIME_NS / `DWI_CORE_CLK_NS      // longest time, rounded down
) (
    input  wire logic              i_core_clk,      // core clock, 100 MHz
    input  wire logic              i_rst_b,         // synchronous reset, active low
    input  wire logic              i_link_clk,      // bus clock from the master
    input  wire logic [3:0]        i_addr_strap,    // address straps, async pins
    input  wire logic              i_wr_guard_b,    // write guard pin, low protects presets
    input  wire logic              i_lnk_start,     // frame start pulse, link domain
    input  wire logic              i_lnk_stop,      // frame stop pulse, link domain
    input  wire logic              i_lnk_byte_vld,  // received byte strobe
    input  wire logic [7:0]        i_lnk_byte,      // received byte
    input  wire logic              i_lnk_step_vld,  // one step clock pulse
    input  wire logic              i_lnk_step_up,   // data level during the step
    output logic                   o_lnk_ack,       // acknowledge for last byte
    output logic                   o_lnk_rd_vld,    // read byte ready
    output logic [7:0]             o_lnk_rd_byte,   // read byte
    output logic [1:0][63:0]       o_tap_sel        // one-hot tap switches per pot
);
    localparam int RESP_CYC = `DWI_WIPER_RESP_CYC;

    function automatic logic op_legal(input logic [7:0] b);
        logic [3:0] op;
        op = b[`DWI_OP_HI:`DWI_OP_LO];
        case (op)
            `DWI_OP_RD_WIPER, `DWI_OP_WR_WIPER, `DWI_OP_STEP:
                op_legal = (b[`DWI_IDX_HI:`DWI_IDX_LO] == 2'h0) && !b[`DWI_ZERO_BIT];
            `DWI_OP_RD_PRESET, `DWI_OP_WR_PRESET, `DWI_OP_PRE2WIP, `DWI_OP_WIP2PRE:
                op_legal = !b[`DWI_ZERO_BIT];
            `DWI_OP_GANG_P2W, `DWI_OP_GANG_W2P:
                op_legal = !b[`DWI_ZERO_BIT] && !b[`DWI_POT_BIT];
            default: op_legal = 1'b0;
        endcase
    endfunction

    function automatic logic op_nv(input logic [3:0] op);
        op_nv = (op == `DWI_OP_WR_PRESET) || (op == `DWI_OP_WIP2PRE) || (op == `DWI_OP_GANG_W2P);
    endfunction

    function automatic logic op_read(input logic [3:0] op);
        op_read = (op == `DWI_OP_RD_WIPER) || (op == `DWI_OP_RD_PRESET);
    endfunction

    function automatic logic op_write(input logic [3:0] op);
        op_write = (op == `DWI_OP_WR_WIPER) || (op == `DWI_OP_WR_PRESET);
    endfunction

    function automatic logic [63:0] onehot(input logic [5:0] v);
        onehot = 64'h0000_0000_0000_0001 << v;
    endfunction

    // ---------------- link domain ----------------
    logic [1:0]         lrst_q;
    logic               lnk_rst_b;
    logic [3:0]         strap1_q, strap2_q;
    logic [1:0]         guard_q;
    logic [1:0]         done_s_q, busy_s_q, rdack_s_q;
    logic [1:0]         cnt_q;
    dwi_pkg::dwi_cmd_s  cmd_q;
    logic               op_ok_q, has_data_q, step_en_q, rd_pend_q;
    logic               cmd_tgl_q, rd_tgl_q, step_tgl_q, step_up_q;
    logic               lnk_busy, addr_hit, frame_go;
    logic               done_tgl_q, rd_ack_q, core_busy_q;   // core answers, only read through the crossing
    logic [7:0]         rd_data_q;                           // held stable until the read handshake closes

    // reset and pins reach the link clock through two flops each
    always_ff @(posedge i_link_clk) begin
        lrst_q   <= {lrst_q[0], i_rst_b};
        strap1_q <= i_addr_strap;
        strap2_q <= strap1_q;
        guard_q  <= {guard_q[0], i_wr_guard_b};
    end
    assign lnk_rst_b = lrst_q[1];

    // busy while a handed command is unfinished or the core is recalling or programming
    assign lnk_busy = (cmd_tgl_q != done_s_q[1]) || busy_s_q[1];                 // RULE_21
    assign addr_hit = (i_lnk_byte[7:4] == DEV_TYPE) && (i_lnk_byte[3:0] == strap2_q) && !lnk_busy; // RULE_24
    // a frame runs only when complete, and never programs a preset while guarded
    assign frame_go = i_lnk_stop && op_ok_q && (!op_write(cmd_q.op) || has_data_q)  // RULE_19 RULE_20
                      && !op_read(cmd_q.op) && (cmd_q.op != `DWI_OP_STEP)
                      && !(op_nv(cmd_q.op) && !guard_q[1]);                      // RULE_22

    // frame decoding: byte counter, latched instruction and the acknowledge
    always_ff @(posedge i_link_clk) begin
        if (!lnk_rst_b) begin
            cnt_q      <= 2'h0;
            cmd_q      <= '0;
            op_ok_q    <= 1'b0;
            has_data_q <= 1'b0;
            step_en_q  <= 1'b0;
            o_lnk_ack  <= 1'b0;
        end else if (i_lnk_start) begin
            cnt_q      <= 2'h0;
            op_ok_q    <= 1'b0;
            has_data_q <= 1'b0;
            step_en_q  <= 1'b0;
            o_lnk_ack  <= 1'b0;
        end else if (i_lnk_stop) begin
            op_ok_q    <= 1'b0;
            step_en_q  <= 1'b0;
        end else if (i_lnk_byte_vld) begin
            case (cnt_q)
                2'h0: begin
                    o_lnk_ack <= addr_hit;                                       // RULE_24
                    cnt_q     <= addr_hit ? 2'h1 : 2'h3;
                end
                2'h1: begin
                    o_lnk_ack <= op_legal(i_lnk_byte);                           // RULE_27
                    op_ok_q   <= op_legal(i_lnk_byte);
                    cmd_q.op  <= i_lnk_byte[`DWI_OP_HI:`DWI_OP_LO];
                    cmd_q.idx <= i_lnk_byte[`DWI_IDX_HI:`DWI_IDX_LO];
                    cmd_q.pot <= i_lnk_byte[`DWI_POT_BIT];
                    step_en_q <= op_legal(i_lnk_byte)                                      // RULE_15
                                 && (i_lnk_byte[`DWI_OP_HI:`DWI_OP_LO] == `DWI_OP_STEP);
                    cnt_q     <= op_legal(i_lnk_byte) ? 2'h2 : 2'h3;
                end
                2'h2: begin
                    // only write instructions take a third byte
                    if (op_write(cmd_q.op)) begin                                // RULE_19
                        o_lnk_ack  <= (cmd_q.op == `DWI_OP_WR_WIPER) || guard_q[1]; // RULE_22
                        has_data_q <= (cmd_q.op == `DWI_OP_WR_WIPER) || guard_q[1];
                        cmd_q.data <= i_lnk_byte;
                    end else begin
                        o_lnk_ack  <= 1'b0;                                      // RULE_20
                        op_ok_q    <= 1'b0;
                    end
                    cnt_q <= 2'h3;
                end
                default: o_lnk_ack <= 1'b0;
            endcase
        end
    end

    // event toggles toward the core; payloads stay frozen until answered
    always_ff @(posedge i_link_clk) begin
        if (!lnk_rst_b) begin
            cmd_tgl_q  <= 1'b0;
            rd_tgl_q   <= 1'b0;
            step_tgl_q <= 1'b0;
            step_up_q  <= 1'b0;
        end else begin
            if (frame_go)
                cmd_tgl_q <= !cmd_tgl_q;
            if (i_lnk_byte_vld && !i_lnk_start && !i_lnk_stop && cnt_q == 2'h1
                && op_legal(i_lnk_byte) && op_read(i_lnk_byte[`DWI_OP_HI:`DWI_OP_LO]))
                rd_tgl_q <= !rd_tgl_q;                                           // RULE_07 RULE_09
            if (i_lnk_step_vld && step_en_q) begin                              // RULE_16
                step_tgl_q <= !step_tgl_q;
                step_up_q  <= i_lnk_step_up;                                     // RULE_23
            end
        end
    end

    // answers from the core, two flops each
    always_ff @(posedge i_link_clk) begin
        if (!lnk_rst_b) begin
            done_s_q  <= 2'h0;
            busy_s_q  <= 2'h3;
            rdack_s_q <= 2'h0;
        end else begin
            done_s_q  <= {done_s_q[0], done_tgl_q};
            busy_s_q  <= {busy_s_q[0], core_busy_q};
            rdack_s_q <= {rdack_s_q[0], rd_ack_q};
        end
    end

    // read byte is taken once the handshake closes; core holds it stable meanwhile
    always_ff @(posedge i_link_clk) begin
        if (!lnk_rst_b) begin
            rd_pend_q     <= 1'b0;
            o_lnk_rd_vld  <= 1'b0;
            o_lnk_rd_byte <= 8'h00;
        end else begin
            if (i_lnk_start || i_lnk_stop)
                rd_pend_q <= 1'b0;
            else if (rd_tgl_q != rdack_s_q[1])
                rd_pend_q <= 1'b1;
            o_lnk_rd_vld <= rd_pend_q && (rd_tgl_q == rdack_s_q[1]) && !i_lnk_start && !i_lnk_stop;
            if (rd_pend_q && rd_tgl_q == rdack_s_q[1])
                o_lnk_rd_byte <= rd_data_q;
        end
    end

    // ---------------- core domain ----------------
    dwi_pkg::dwi_core_st_e state_q;
    logic [2:0]         sync1_q, sync2_q, seen_q, ev;
    logic [19:0]        nv_cnt_q;
    logic [1:0][5:0]    wiper_q;
    logic [5:0]         preset_q [2][4] = '{default: `DWI_PRESET_BLANK}; // blank cells, never reset
    logic               cmd_ev, rd_ev, step_ev;

    // toggles from the link: bit0 command, bit1 read, bit2 step
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            seen_q  <= 3'h0;
        end else begin
            sync1_q <= {step_tgl_q, rd_tgl_q, cmd_tgl_q};
            sync2_q <= sync1_q;
            seen_q  <= sync2_q;
        end
    end
    assign ev      = sync2_q ^ seen_q;
    assign cmd_ev  = ev[0] && (state_q == dwi_pkg::CORE_IDLE);
    assign rd_ev   = ev[1];
    assign step_ev = ev[2] && (state_q == dwi_pkg::CORE_IDLE);

    // sequencer: recall after reset, then commands, programming wait for presets
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            state_q     <= dwi_pkg::CORE_INIT;
            core_busy_q <= 1'b1;
            done_tgl_q  <= 1'b0;
            nv_cnt_q    <= 20'h0;
        end else begin
            case (state_q)
                dwi_pkg::CORE_INIT: begin
                    state_q     <= dwi_pkg::CORE_IDLE;                           // RULE_03
                    core_busy_q <= 1'b0;
                end
                dwi_pkg::CORE_IDLE: begin
                    if (cmd_ev && op_nv(cmd_q.op)) begin                         // RULE_06 RULE_18
                        state_q     <= dwi_pkg::CORE_NVWAIT;
                        core_busy_q <= 1'b1;
                        nv_cnt_q    <= 20'(NV_WRITE_CYC - 1);
                    end else if (cmd_ev) begin
                        done_tgl_q <= !done_tgl_q;
                    end
                end
                dwi_pkg::CORE_NVWAIT: begin
                    if (nv_cnt_q == 20'h0) begin                                 // RULE_21
                        state_q     <= dwi_pkg::CORE_IDLE;
                        core_busy_q <= 1'b0;
                        done_tgl_q  <= !done_tgl_q;
                    end else begin
                        nv_cnt_q <= nv_cnt_q - 20'h1;
                    end
                end
                default: state_q <= dwi_pkg::CORE_INIT;
            endcase
        end
    end

    // wiper registers: volatile, so reset clears them and init reloads preset zero
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            wiper_q <= {`DWI_WIPER_RST, `DWI_WIPER_RST};                          // RULE_01 RULE_04
        end else if (state_q == dwi_pkg::CORE_INIT) begin
            wiper_q[0] <= preset_q[0][0];                                        // RULE_03
            wiper_q[1] <= preset_q[1][0];
        end else if (cmd_ev) begin
            case (cmd_q.op)
                `DWI_OP_WR_WIPER: wiper_q[cmd_q.pot] <= cmd_q.data[5:0];         // RULE_08
                `DWI_OP_PRE2WIP:  wiper_q[cmd_q.pot] <= preset_q[cmd_q.pot][cmd_q.idx]; // RULE_11
                `DWI_OP_GANG_P2W: begin                                          // RULE_13
                    wiper_q[0] <= preset_q[0][cmd_q.idx];
                    wiper_q[1] <= preset_q[1][cmd_q.idx];
                end
                default: wiper_q <= wiper_q;
            endcase
        end else if (step_ev) begin
            // saturate rather than wrap: a wrap would jump the tap end to end
            if (step_up_q && wiper_q[cmd_q.pot] != `DWI_WIPER_MAX)               // RULE_25
                wiper_q[cmd_q.pot] <= wiper_q[cmd_q.pot] + 6'h01;                // RULE_23
            else if (!step_up_q && wiper_q[cmd_q.pot] != `DWI_WIPER_MIN)
                wiper_q[cmd_q.pot] <= wiper_q[cmd_q.pot] - 6'h01;
        end
    end

    // preset store: not reset, it stands for nonvolatile cells that keep their value
    always_ff @(posedge i_core_clk) begin
        if (cmd_ev) begin
            case (cmd_q.op)
                `DWI_OP_WR_PRESET: preset_q[cmd_q.pot][cmd_q.idx] <= cmd_q.data[5:0]; // RULE_05 RULE_10
                `DWI_OP_WIP2PRE:   preset_q[cmd_q.pot][cmd_q.idx] <= wiper_q[cmd_q.pot]; // RULE_12
                `DWI_OP_GANG_W2P: begin                                           // RULE_14
                    preset_q[0][cmd_q.idx] <= wiper_q[0];
                    preset_q[1][cmd_q.idx] <= wiper_q[1];
                end
                default: ;
            endcase
        end
    end

    // read answer: value in the low six bits, upper two zero
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            rd_ack_q  <= 1'b0;
            rd_data_q <= 8'h00;
        end else if (rd_ev) begin
            rd_ack_q <= sync2_q[1];
            if (cmd_q.op == `DWI_OP_RD_WIPER)
                rd_data_q <= {2'h0, wiper_q[cmd_q.pot]};                         // RULE_07 RULE_26
            else
                rd_data_q <= {2'h0, preset_q[cmd_q.pot][cmd_q.idx]};             // RULE_09 RULE_26
        end
    end

    // tap drive per pot: the switch moves only after the response delay
    logic [1:0][5:0]    shown_q;
    logic [1:0][7:0]    dly_q;
    for (genvar p = 0; p < 2; p++) begin : g_tap
        always_ff @(posedge i_core_clk) begin
            if (!i_rst_b) begin
                shown_q[p]   <= `DWI_WIPER_RST;
                dly_q[p]     <= 8'h00;
                o_tap_sel[p] <= `DWI_TAP_RST;
            end else begin
                shown_q[p] <= wiper_q[p];
                if (wiper_q[p] != shown_q[p])
                    dly_q[p] <= 8'(RESP_CYC);                                    // RULE_17
                else if (dly_q[p] != 8'h00)
                    dly_q[p] <= dly_q[p] - 8'h01;
                if (wiper_q[p] == shown_q[p] && dly_q[p] == 8'h01)
                    o_tap_sel[p] <= onehot(wiper_q[p]);                          // RULE_02
            end
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    tap_onehot_a: assert property ($onehot(o_tap_sel[0]) && $onehot(o_tap_sel[1])) // RULE_02
        else $error("tap select is not one-hot");
    init_recall_a: assert property (state_q == dwi_pkg::CORE_INIT |=>              // RULE_03
        wiper_q[0] == $past(preset_q[0][0]) && wiper_q[1] == $past(preset_q[1][0]) && !core_busy_q)
        else $error("wiper not loaded from preset zero");
    nv_bound_a: assert property (state_q == dwi_pkg::CORE_NVWAIT |-> nv_cnt_q < 20'(NV_WRITE_CYC)) // RULE_06
        else $error("programming wait longer than write time");
    wr_wiper_a: assert property (cmd_ev && cmd_q.op == `DWI_OP_WR_WIPER |=>         // RULE_08
        wiper_q[$past(cmd_q.pot)] == $past(cmd_q.data[5:0]) && state_q == dwi_pkg::CORE_IDLE)
        else $error("wiper write lost or started programming");
    gang_store_a: assert property (cmd_ev && cmd_q.op == `DWI_OP_GANG_W2P |=>       // RULE_14
        preset_q[0][$past(cmd_q.idx)] == $past(wiper_q[0]) && state_q == dwi_pkg::CORE_NVWAIT)
        else $error("gang store failed");
    step_sat_a: assert property (step_ev && step_up_q && wiper_q[cmd_q.pot] == `DWI_WIPER_MAX // RULE_25
        |=> wiper_q[$past(cmd_q.pot)] == `DWI_WIPER_MAX)
        else $error("wiper wrapped at top");
    step_down_a: assert property (step_ev && !step_up_q && wiper_q[cmd_q.pot] != `DWI_WIPER_MIN // RULE_23
        |=> wiper_q[$past(cmd_q.pot)] == $past(wiper_q[cmd_q.pot]) - 6'h01)
        else $error("down step wrong");
    tap_delay_a: assert property (wiper_q[0] != shown_q[0] |=> $stable(o_tap_sel[0])[*2]) // RULE_17
        else $error("tap moved before response delay");
    rd_upper_a: assert property (rd_ev |=> rd_data_q[7:6] == 2'h0 && rd_ack_q == $past(sync2_q[1])) // RULE_26
        else $error("read byte upper bits set");
    addr_miss_a: assert property (@(posedge i_link_clk) disable iff (!lnk_rst_b)    // RULE_24
        i_lnk_byte_vld && !i_lnk_start && !i_lnk_stop && cnt_q == 2'h0 && i_lnk_byte[3:0] != strap2_q
        |=> !o_lnk_ack && cnt_q == 2'h3)
        else $error("acknowledged foreign address");
    busy_nack_a: assert property (@(posedge i_link_clk) disable iff (!lnk_rst_b)   // RULE_21
        i_lnk_byte_vld && !i_lnk_start && !i_lnk_stop && cnt_q == 2'h0 && lnk_busy |=> !o_lnk_ack)
        else $error("acknowledged while busy");
    guard_nack_a: assert property (@(posedge i_link_clk) disable iff (!lnk_rst_b)  // RULE_22
        i_lnk_byte_vld && !i_lnk_start && !i_lnk_stop && cnt_q == 2'h2
        && cmd_q.op == `DWI_OP_WR_PRESET && !guard_q[1] |=> !o_lnk_ack && !has_data_q)
        else $error("guarded preset write acknowledged");
    bad_op_a: assert property (@(posedge i_link_clk) disable iff (!lnk_rst_b)      // RULE_27
        i_lnk_byte_vld && !i_lnk_start && !i_lnk_stop && cnt_q == 2'h1 && !op_legal(i_lnk_byte)
        |=> !o_lnk_ack && !op_ok_q)
        else $error("illegal instruction accepted");

    nv_done_c:   cover property (state_q == dwi_pkg::CORE_NVWAIT ##1 state_q == dwi_pkg::CORE_IDLE);
    step_top_c:  cover property (step_ev && step_up_q && wiper_q[cmd_q.pot] == `DWI_WIPER_MAX);
    rd_done_c:   cover property (@(posedge i_link_clk) o_lnk_rd_vld);
    gang_load_c: cover property (cmd_ev && cmd_q.op == `DWI_OP_GANG_P2W);
endmodule // dwi_logic

// >>> testbench/dwi_host.sv
`timescale 1ns/1ps
// master model: each change lands 1 ns after a link rising edge
module dwi_host (
    input  wire logic       i_link_clk, // link clock
    input  wire logic       i_rd_vld,   // read byte ready
    output logic            o_start,    // frame start
    output logic            o_stop,     // frame stop
    output logic            o_vld,      // byte strobe
    output logic [7:0]      o_byte,     // byte sent
    output logic            o_step,     // step pulse
    output logic            o_up        // step direction
);
    initial {o_start, o_stop, o_vld, o_byte, o_step, o_up} = '0;
    task automatic tick(input int n); repeat (n) @(posedge i_link_clk); #1; endtask
    // released data turns inverse so a stale byte never looks fresh
    task automatic put(input logic [7:0] b); o_byte = b; o_vld = 1; tick(1); o_vld = 0; o_byte = ~b; tick(1); endtask
    task automatic frame(input logic s); o_start = s; o_stop = ~s; tick(1); {o_start, o_stop} = '0; endtask
    // wide spacing so two steps never merge in the crossing
    task automatic step(input logic u); o_step = 1; o_up = u; tick(1); o_step = 0; o_up = ~u; tick(6); endtask
    task automatic wait_rd(); for (int i = 0; i < 40 && i_rd_vld !== 1'b1; i++) tick(1); endtask
endmodule // dwi_host

// >>> testbench/dual_wiper_instruction_logic_tb.sv
`timescale 1ns/1ps
module dual_wiper_instruction_logic_tb;
    logic             core_clk, link_clk, rst_b, guard_b;
    logic             start, stop, vld, stp, up, ack, rd_vld;
    logic [7:0]       bus_byte, rd_byte, r;
    logic [3:0]       strap, tgt = 4'h5;
    logic [2:0]       a;
    logic [1:0][63:0] tap;
    int               n_mismatch = 0, cmp_count = 0;
    always #5 core_clk = ~core_clk;
    // odd offset so link edges wander against core edges
    initial begin link_clk = 1'b0; #3.3; forever #6 link_clk = ~link_clk; end
    dwi_logic #(.NV_WRITE_CYC(50)) dwi_logic_inst (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_link_clk(link_clk),
        .i_addr_strap(strap), .i_wr_guard_b(guard_b), .i_lnk_start(start), .i_lnk_stop(stop), .i_lnk_byte_vld(vld),
        .i_lnk_byte(bus_byte), .i_lnk_step_vld(stp), .i_lnk_step_up(up), .o_lnk_ack(ack), .o_lnk_rd_vld(rd_vld),
        .o_lnk_rd_byte(rd_byte), .o_tap_sel(tap));
    dwi_host dwi_host_inst (.i_link_clk(link_clk), .i_rd_vld(rd_vld), .o_start(start), .o_stop(stop), .o_vld(vld),
        .o_byte(bus_byte), .o_step(stp), .o_up(up));
    task automatic chk(input string what, input logic [63:0] exp, got);
        cmp_count++;
        if (got !== exp) begin n_mismatch++; $display("mismatch %s expected %h seen %h", what, exp, got); end
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // gap first covers any programming cycle; kind 1 writes, 2 reads, 3 steps by dat[2:0]
    task automatic run(input logic [7:0] ins, input int kind, input logic [7:0] dat = 8'h00);
        dwi_host_inst.tick(80);
        dwi_host_inst.frame(1'b1);
        dwi_host_inst.put({4'hc, tgt});
        a = {ack, 2'b00};
        dwi_host_inst.put(ins);
        a[1] = ack;
        if (kind == 1) begin dwi_host_inst.put(dat); a[0] = ack; end
        if (kind == 2) begin dwi_host_inst.wait_rd(); r = rd_vld ? rd_byte : 8'hxx; end
        if (kind == 3) for (int i = 0; i < 3; i++) dwi_host_inst.step(dat[i]);
        dwi_host_inst.frame(1'b0);
    endtask
    task automatic t_wiper();
        chk("recall", 64'h1 << 32, tap[1]);
        run(8'ha0, 1, 8'hfa); chk("acks", 3'b111, a);
        run(8'h90, 2); chk("wiper", 8'h3a, r);
        chk("tap", 64'h1 << 58, tap[0]);
    endtask
    // poll right after a programming stop must be refused
    task automatic t_preset();
        run(8'hc9, 1, 8'h15); dwi_host_inst.frame(1'b1); dwi_host_inst.put({4'hc, tgt});
        chk("busy", 1'b0, ack);
        dwi_host_inst.frame(1'b0); run(8'hb9, 2); chk("preset", 8'h15, r);
        run(8'hd9, 0); run(8'hec, 0); run(8'hbc, 2); chk("copy out", 8'h3a, r);
        chk("copy in", 64'h1 << 21, tap[1]);
    endtask
    task automatic t_gang();
        run(8'h84, 0); run(8'hb5, 2); chk("gang out", 8'h15, r);
        run(8'h10, 0); dwi_host_inst.tick(20);
        chk("gang in0", 64'h1 << 32, tap[0]);
        chk("gang in1", 64'h1 << 32, tap[1]);
    endtask
    task automatic t_step();
        run(8'ha1, 1, 8'h3e); run(8'h21, 3, 8'h07); run(8'h91, 2); chk("up", 8'h3f, r);
        run(8'h21, 3, 8'h02); run(8'h91, 2); chk("mix", 8'h3e, r);
    endtask
    // refusals must leave every register as it was
    task automatic t_refuse();
        guard_b = 1'b0; run(8'hc0, 1, 8'h11); chk("guard", 3'b110, a);
        run(8'hec, 0); chk("guard xfr ack", 3'b110, a);
        guard_b = 1'b1; strap = 4'h6; run(8'ha0, 1, 8'h05); chk("miss", 3'b000, a);
        tgt = 4'h6; run(8'hde, 0); chk("bad bit", 3'b100, a);
        run(8'h30, 0); chk("bad op", 3'b100, a);
        run(8'hb0, 2); chk("guarded", 8'h20, r);
        run(8'h90, 2); chk("kept", 8'h20, r);
        run(8'hbc, 2); chk("guard xfr", 8'h3a, r);
    endtask
    initial begin
        core_clk = 1'b0; rst_b = 1'b0; guard_b = 1'b1; strap = 4'h5;
        repeat (20) @(posedge core_clk);
        #1 chk("reset tap", 64'h1, tap[0]);
        rst_b = 1'b1;
        dwi_host_inst.tick(20);
        t_wiper(); t_preset(); t_gang(); t_step(); t_refuse();
        give_verdict();
    end
    // about two dozen frames of under 2 us each
    initial begin #150000; n_mismatch++; give_verdict(); end
endmodule // dual_wiper_instruction_logic_tb
